/* File: logic/compare_timer_pkg.sv */
// constants shared by the dual mode compare timer
package compare_timer_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CONTROL      = 16'hFFB6;
    localparam logic [15:0] ADDR_STATUS       = 16'hFFB7;
    localparam logic [15:0] ADDR_COUNT_HIGH   = 16'hFFB8;
    localparam logic [15:0] ADDR_COUNT_LOW    = 16'hFFB9;
    localparam logic [15:0] ADDR_COMPARE_HIGH = 16'hFFBA;
    localparam logic [15:0] ADDR_COMPARE_LOW  = 16'hFFBB;
    localparam logic [15:0] ADDR_CLOCK_STOP   = 16'hFFFA;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] COUNT_RESET      = 8'h00;
    localparam logic [7:0] COMPARE_RESET    = 8'hFF;
    localparam logic [7:0] CLOCK_STOP_RESET = 8'hFF;
    localparam logic [7:0] WRITE_ONLY_READ  = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES    = 8'hFF;

    // ------------------------------------------------------------------
    // timer_control fields
    // ------------------------------------------------------------------
    localparam int OUT_LEVEL_HIGH_BIT = 7;
    localparam int SEL_HIGH_TOP_BIT   = 6;
    localparam int SEL_HIGH_LSB       = 4;
    localparam int OUT_LEVEL_LOW_BIT  = 3;
    localparam int SEL_LOW_LSB        = 0;

    // ------------------------------------------------------------------
    // timer_control_status fields
    // ------------------------------------------------------------------
    localparam int OVF_HIGH_BIT   = 7;
    localparam int MATCH_HIGH_BIT = 6;
    localparam int OVIE_HIGH_BIT  = 5;
    localparam int CLEAR_HIGH_BIT = 4;
    localparam int OVF_LOW_BIT    = 3;
    localparam int MATCH_LOW_BIT  = 2;
    localparam int OVIE_LOW_BIT   = 1;
    localparam int CLEAR_LOW_BIT  = 0;

    // module_clock_stop field
    localparam int STANDBY_BIT = 2;

    // ------------------------------------------------------------------
    // clock select codes and prescaler taps
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_ALT_A    = 3'h0;
    localparam logic [2:0] SEL_ALT_B    = 3'h1;
    localparam logic [2:0] SEL_DIV32    = 3'h4;
    localparam logic [2:0] SEL_DIV16    = 3'h5;
    localparam logic [2:0] SEL_DIV4     = 3'h6;
    localparam logic [2:0] SEL_SUB_DIV4 = 3'h7;
    localparam int         PRESCALE_W   = 5;
    localparam logic [4:0] TAP_DIV32    = 5'h1F;
    localparam logic [3:0] TAP_DIV16    = 4'hF;
    localparam logic [1:0] TAP_DIV4     = 2'h3;
    localparam logic [1:0] SUB_TAP_DIV4 = 2'h3;

endpackage

/* File: logic/timer_pin_sync.sv */
// two-stage synchroniser with edge pulses for an asynchronous pin
`timescale 1ns/10ps
module timer_pin_sync
    import compare_timer_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and edges
    input  wire logic pinIn,
    output logic      riseOut,
    output logic      fallOut
);
    logic stage1_reg;
    logic stage2_reg;
    logic last_reg;

    // ------------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------------
    // idle high so an undriven event line never counts at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
            last_reg   <= 1'b1;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            last_reg   <= stage2_reg;
        end
    end

    assign riseOut = stage2_reg & ~last_reg;
    assign fallOut = ~stage2_reg & last_reg;
endmodule

/* File: logic/timer_tick_select.sv */
// count-enable multiplexer for one counter half
`timescale 1ns/10ps
module timer_tick_select
    import compare_timer_pkg::*;
#(
    parameter bit LOW_HALF = 1'b1
) (
    // selection
    input  wire logic [2:0] selCode,
    input  wire logic       active,
    // tick sources
    input  wire logic       tickDiv32,
    input  wire logic       tickDiv16,
    input  wire logic       tickDiv4,
    input  wire logic       tickSub,
    input  wire logic       tickAlt,
    // result
    output logic            tickOut
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // unavailable codes give no tick, the counter simply holds
    function automatic logic pickTick(input logic [2:0] code, input logic alt,
                                      input logic d32, input logic d16,
                                      input logic d4, input logic sub);
        case (code)
            SEL_ALT_A:    pickTick = alt;
            SEL_ALT_B:    pickTick = LOW_HALF ? alt : 1'b0;
            SEL_DIV32:    pickTick = d32;
            SEL_DIV16:    pickTick = d16;
            SEL_DIV4:     pickTick = d4;
            SEL_SUB_DIV4: pickTick = sub;
            default:      pickTick = 1'b0;
        endcase
    endfunction

    assign tickOut = active & pickTick(selCode, tickAlt, tickDiv32, tickDiv16,
                                       tickDiv4, tickSub);
endmodule

/* File: logic/dual_mode_compare_timer.sv */
// 16-bit compare timer, splittable into two 8-bit timers
// Operation
// - select top zero joins halves into 16 bits; only high select zero cascades
// - 16-bit rollover sets high overflow flag
// - overflow request needs enable; irq needs mask
// - clear-high bit clears 16-bit counter on match
// - select top one splits into two counters
// - 8-bit rollover sets that half's overflow flag
// - each half clears on own match
// - 16-bit match sets flag and request together
// - 8-bit match sets half flag and request
// - compare match toggles associated output pin
// - writing level bit drives pin immediately
// - high select decode: cascade, none, four clocks
// - low select decode: event edges, four clocks
// - control register write-only, resets to zero
// - flag bits only cleared by writing zero
// - reset: counters zero, compares ones, status zero
// - 16-bit byte accesses pass temporary latch
// - event edge chosen by outside select bit
// - pin function change while low may count
// - standby bit zero halts the timer
`timescale 1ns/10ps
module dual_mode_compare_timer
    import compare_timer_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // peripheral bus
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    output logic      [7:0]  rdData,
    // pins
    input  wire logic        eventInputPin,
    input  wire logic        subClockPin,
    output logic             toggleOutHighPin,
    output logic             toggleOutLowPin,
    // outside control bits
    input  wire logic        eventEdgeSelect,
    input  wire logic        eventPinFunction,
    // interrupt controller
    input  wire logic        irqEnableHigh,
    input  wire logic        irqEnableLow,
    input  wire logic        irqClearHigh,
    input  wire logic        irqClearLow,
    output logic             irqRequestHigh,
    output logic             irqRequestLow,
    output logic             cpuIrqHigh,
    output logic             cpuIrqLow
);
    logic [7:0]            control_reg;
    logic [7:0]            status_reg;
    logic [7:0]            clockStop_reg;
    logic [7:0]            countHigh_reg;
    logic [7:0]            countLow_reg;
    logic [7:0]            compareHigh_reg;
    logic [7:0]            compareLow_reg;
    logic [7:0]            temp_reg;
    logic [3:0]            armed_reg;
    logic [PRESCALE_W-1:0] prescale_reg;
    logic [1:0]            subCount_reg;
    logic                  eqHighPrev_reg;
    logic                  eqLowPrev_reg;
    logic                  irqReqHigh_reg;
    logic                  irqReqLow_reg;
    logic                  outHigh_reg;
    logic                  outLow_reg;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic wideMode, active;
    logic wrCtrl, wrStat, wrCntH, wrCntL, wrCmpH, wrCmpL, wrStop;
    logic rdStat, rdCntH;
    assign wideMode = ~control_reg[SEL_HIGH_TOP_BIT];
    assign active   = clockStop_reg[STANDBY_BIT];
    assign wrCtrl   = wrEn && addr == ADDR_CONTROL;
    assign wrStat   = wrEn && addr == ADDR_STATUS;
    assign wrCntH   = wrEn && addr == ADDR_COUNT_HIGH;
    assign wrCntL   = wrEn && addr == ADDR_COUNT_LOW;
    assign wrCmpH   = wrEn && addr == ADDR_COMPARE_HIGH;
    assign wrCmpL   = wrEn && addr == ADDR_COMPARE_LOW;
    assign wrStop   = wrEn && addr == ADDR_CLOCK_STOP;
    assign rdStat   = rdEn && addr == ADDR_STATUS;
    assign rdCntH   = rdEn && addr == ADDR_COUNT_HIGH;

    // ------------------------------------------------------------------
    // tick sources
    // ------------------------------------------------------------------
    logic evRise, evFall, subRise, evTick, tickSub;
    logic tickDiv32, tickDiv16, tickDiv4, tickLow, tickHigh;
    logic lowWrap;

    // with the pin function off the line idles high, so turning it on
    // while the pin is low looks like a falling edge
    timer_pin_sync eventSync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (eventPinFunction ? eventInputPin : 1'b1),
        .riseOut (evRise),
        .fallOut (evFall)
    );

    timer_pin_sync subSync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (subClockPin),
        .riseOut (subRise),
        .fallOut ()
    );

    assign evTick    = eventEdgeSelect ? evRise : evFall;
    assign tickSub   = subRise && subCount_reg == SUB_TAP_DIV4;
    assign tickDiv32 = prescale_reg == TAP_DIV32;
    assign tickDiv16 = prescale_reg[3:0] == TAP_DIV16;
    assign tickDiv4  = prescale_reg[1:0] == TAP_DIV4;

    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_reg <= '0;
            subCount_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 1'b1;
            if (subRise) begin
                subCount_reg <= subCount_reg + 1'b1;
            end
        end
    end

    timer_tick_select #(.LOW_HALF(1'b1)) lowSelect (
        .selCode   (control_reg[SEL_LOW_LSB +: 3]),
        .active    (active),
        .tickDiv32 (tickDiv32),
        .tickDiv16 (tickDiv16),
        .tickDiv4  (tickDiv4),
        .tickSub   (tickSub),
        .tickAlt   (evTick),
        .tickOut   (tickLow)
    );

    timer_tick_select #(.LOW_HALF(1'b0)) highSelect (
        .selCode   (control_reg[SEL_HIGH_LSB +: 3]),
        .active    (active),
        .tickDiv32 (tickDiv32),
        .tickDiv16 (tickDiv16),
        .tickDiv4  (tickDiv4),
        .tickSub   (tickSub),
        .tickAlt   (lowWrap),
        .tickOut   (tickHigh)
    );

    // ------------------------------------------------------------------
    // compare and counting
    // ------------------------------------------------------------------
    logic eqWide, eqHigh, eqLow, clrWide, clrHigh, clrLow;
    logic matchHighEvt, matchLowEvt, ovfHighEvt, ovfLowEvt;
    assign eqWide  = {countHigh_reg, countLow_reg} == {compareHigh_reg, compareLow_reg};
    assign eqHigh  = wideMode ? eqWide : countHigh_reg == compareHigh_reg;
    assign eqLow   = ~wideMode && countLow_reg == compareLow_reg;
    assign clrWide = wideMode && tickLow && eqWide && status_reg[CLEAR_HIGH_BIT];
    assign clrHigh = ~wideMode && tickHigh && eqHigh && status_reg[CLEAR_HIGH_BIT];
    assign clrLow  = ~wideMode && tickLow && eqLow && status_reg[CLEAR_LOW_BIT];
    assign lowWrap = tickLow && countLow_reg == BYTE_ALL_ONES && !clrWide && !clrLow;
    // equality is edge detected so a held match flags once
    assign matchHighEvt = eqHigh && !eqHighPrev_reg;
    assign matchLowEvt  = eqLow && !eqLowPrev_reg;
    assign ovfHighEvt   = wideMode
        ? lowWrap && countHigh_reg == BYTE_ALL_ONES
        : tickHigh && !clrHigh && countHigh_reg == BYTE_ALL_ONES;
    assign ovfLowEvt    = ~wideMode && lowWrap;

    // cpu writes win over a tick in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            countLow_reg <= COUNT_RESET;
        end else if (wrCntL) begin
            countLow_reg <= wrData;
        end else if (clrWide || clrLow) begin
            countLow_reg <= '0;
        end else if (tickLow) begin
            countLow_reg <= countLow_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            countHigh_reg <= COUNT_RESET;
        end else if (wideMode && wrCntL) begin
            countHigh_reg <= temp_reg;
        end else if (!wideMode && wrCntH) begin
            countHigh_reg <= wrData;
        end else if (clrWide || clrHigh) begin
            countHigh_reg <= '0;
        end else if (tickHigh) begin
            countHigh_reg <= countHigh_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            compareHigh_reg <= COMPARE_RESET;
            compareLow_reg  <= COMPARE_RESET;
        end else begin
            if (wideMode && wrCmpL) begin
                compareHigh_reg <= temp_reg;
            end else if (!wideMode && wrCmpH) begin
                compareHigh_reg <= wrData;
            end
            if (wrCmpL) begin
                compareLow_reg <= wrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eqHighPrev_reg <= 1'b0;
            eqLowPrev_reg  <= 1'b0;
        end else begin
            eqHighPrev_reg <= eqHigh;
            eqLowPrev_reg  <= eqLow;
        end
    end

    // ------------------------------------------------------------------
    // temporary latch
    // ------------------------------------------------------------------
    // only an upper-then-lower pair moves a whole 16-bit value
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_reg <= '0;
        end else if (wideMode && (wrCntH || wrCmpH)) begin
            temp_reg <= wrData;
        end else if (wideMode && rdCntH) begin
            temp_reg <= countLow_reg;
        end
    end

    // ------------------------------------------------------------------
    // control, standby and output pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg   <= CONTROL_RESET;
            clockStop_reg <= CLOCK_STOP_RESET;
        end else begin
            if (wrCtrl) begin
                control_reg <= wrData;
            end
            if (wrStop) begin
                clockStop_reg <= wrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outHigh_reg <= 1'b0;
            outLow_reg  <= 1'b0;
        end else begin
            if (wrCtrl) begin
                outHigh_reg <= wrData[OUT_LEVEL_HIGH_BIT];
            end else if (matchHighEvt) begin
                outHigh_reg <= ~outHigh_reg;
            end
            if (wrCtrl) begin
                outLow_reg <= wrData[OUT_LEVEL_LOW_BIT];
            end else if (matchLowEvt) begin
                outLow_reg <= ~outLow_reg;
            end
        end
    end

    assign toggleOutHighPin = outHigh_reg;
    assign toggleOutLowPin  = outLow_reg;

    // ------------------------------------------------------------------
    // status flags and interrupt requests
    // ------------------------------------------------------------------
    logic [3:0] flagSet, flagNow, flagWrZero;
    assign flagSet    = {ovfHighEvt, matchHighEvt, ovfLowEvt, matchLowEvt};
    assign flagNow    = {status_reg[OVF_HIGH_BIT], status_reg[MATCH_HIGH_BIT],
                         status_reg[OVF_LOW_BIT], status_reg[MATCH_LOW_BIT]};
    assign flagWrZero = ~{wrData[OVF_HIGH_BIT], wrData[MATCH_HIGH_BIT],
                          wrData[OVF_LOW_BIT], wrData[MATCH_LOW_BIT]};

    logic [3:0] flagNext;
    always_comb begin
        flagNext = flagNow;
        if (wrStat) begin
            flagNext = flagNow & ~(flagWrZero & armed_reg);
        end
        flagNext = flagNext | flagSet; // set wins over clear
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg <= STATUS_RESET;
            armed_reg  <= '0;
        end else begin
            status_reg[OVF_HIGH_BIT]   <= flagNext[3];
            status_reg[MATCH_HIGH_BIT] <= flagNext[2];
            status_reg[OVF_LOW_BIT]    <= flagNext[1];
            status_reg[MATCH_LOW_BIT]  <= flagNext[0];
            if (wrStat) begin
                status_reg[OVIE_HIGH_BIT]  <= wrData[OVIE_HIGH_BIT];
                status_reg[CLEAR_HIGH_BIT] <= wrData[CLEAR_HIGH_BIT];
                status_reg[OVIE_LOW_BIT]   <= wrData[OVIE_LOW_BIT];
                status_reg[CLEAR_LOW_BIT]  <= wrData[CLEAR_LOW_BIT];
                armed_reg <= '0;
            end else if (rdStat) begin
                armed_reg <= armed_reg | flagNow;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqReqHigh_reg <= 1'b0;
            irqReqLow_reg  <= 1'b0;
        end else begin
            irqReqHigh_reg <= (irqReqHigh_reg && !irqClearHigh) || matchHighEvt
                              || (ovfHighEvt && status_reg[OVIE_HIGH_BIT]);
            irqReqLow_reg  <= (irqReqLow_reg && !irqClearLow) || matchLowEvt
                              || (ovfLowEvt && status_reg[OVIE_LOW_BIT]);
        end
    end

    assign irqRequestHigh = irqReqHigh_reg;
    assign irqRequestLow  = irqReqLow_reg;
    assign cpuIrqHigh     = irqReqHigh_reg & irqEnableHigh;
    assign cpuIrqLow      = irqReqLow_reg & irqEnableLow;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= '0;
        end else if (rdEn) begin
            case (addr)
                ADDR_CONTROL:      rdData <= WRITE_ONLY_READ;
                ADDR_STATUS:       rdData <= status_reg;
                ADDR_COUNT_HIGH:   rdData <= countHigh_reg;
                ADDR_COUNT_LOW:    rdData <= wideMode ? temp_reg : countLow_reg;
                ADDR_COMPARE_HIGH: rdData <= compareHigh_reg;
                ADDR_COMPARE_LOW:  rdData <= compareLow_reg;
                ADDR_CLOCK_STOP:   rdData <= clockStop_reg;
                default:           rdData <= UNMAPPED_READ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence busIdle;
        !wrEn;
    endsequence

    chk_level_write_high: assert property (@(posedge clk) disable iff (rst)
        wrCtrl |=> toggleOutHighPin == $past(wrData[OUT_LEVEL_HIGH_BIT]))
        else $error("high level write not applied");
    chk_ovf_high_flag: assert property (@(posedge clk) disable iff (rst)
        ovfHighEvt |=> status_reg[OVF_HIGH_BIT])
        else $error("high overflow flag not set");
    chk_match_flag_req: assert property (@(posedge clk) disable iff (rst)
        matchHighEvt |=> status_reg[MATCH_HIGH_BIT] && irqRequestHigh)
        else $error("match flag and request not set together");
    chk_wide_cascade: assert property (@(posedge clk) disable iff (rst)
        (wideMode && lowWrap && !clrWide) ##0 busIdle
        |=> countHigh_reg == $past(countHigh_reg) + 8'h01 && countLow_reg == 8'h00)
        else $error("high byte missed cascade carry");
    chk_flag_no_set: assert property (@(posedge clk) disable iff (rst)
        wrStat && !status_reg[OVF_LOW_BIT] && !ovfLowEvt |=> !status_reg[OVF_LOW_BIT])
        else $error("software set an overflow flag");
    chk_ovf_gate_low: assert property (@(posedge clk) disable iff (rst)
        !irqRequestLow && ovfLowEvt && !status_reg[OVIE_LOW_BIT] && !matchLowEvt
        |=> !irqRequestLow)
        else $error("low request raised while disabled");
    chk_toggle_match: assert property (@(posedge clk) disable iff (rst)
        matchLowEvt && !wrCtrl |=> toggleOutLowPin != $past(toggleOutLowPin))
        else $error("low pin did not toggle on match");
    chk_wide_clear: assert property (@(posedge clk) disable iff (rst)
        clrWide ##0 busIdle |=> {countHigh_reg, countLow_reg} == 16'h0000)
        else $error("wide counter not cleared on match");
    chk_standby_hold: assert property (@(posedge clk) disable iff (rst)
        !active ##0 busIdle |=> $stable(countLow_reg) && $stable(countHigh_reg))
        else $error("counter moved in standby");
endmodule

/* File: dv/cpu_bus_model.sv */
// cpu side model of the peripheral byte bus
`timescale 1ns/10ps
module cpu_bus_model (
    // bus
    input  wire logic        clk,
    input  wire logic [7:0]  rdData,
    output logic      [15:0] addr   = 16'h0000,
    output logic      [7:0]  wrData = 8'h00,
    output logic             wrEn   = 1'b0,
    output logic             rdEn   = 1'b0
);
    // one byte write, strobe held for exactly one rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr   = a;
        wrData = d;
        wrEn   = 1'b1;
        @(negedge clk);
        wrEn   = 1'b0;
    endtask
    // read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rdEn = 1'b1;
        @(negedge clk);
        rdEn = 1'b0;
        d    = rdData;
    endtask
endmodule

/* File: dv/test_dual_mode_compare_timer.sv */
// self-checking bench for the dual mode compare timer
`timescale 1ns/10ps
module test_dual_mode_compare_timer
    import compare_timer_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, enHi = 1'b1, enLo = 1'b0, clrLo = 1'b0;
    logic        evPin = 1'b0, evFunc = 1'b0, evEdge = 1'b0;
    logic        wrEn, rdEn, hiPin, loPin, reqHi, reqLo, cpuHi, cpuLo;
    logic [15:0] addr;
    logic [7:0]  wrData, rdData, v;
    int          errors = 0, checks_done = 0;
    always #25 clk = ~clk;
    cpu_bus_model cpu_u (.clk(clk), .rdData(rdData), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn));
    dual_mode_compare_timer dut_u (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .eventInputPin(evPin),
        .subClockPin(1'b0), .toggleOutHighPin(hiPin), .toggleOutLowPin(loPin),
        .eventEdgeSelect(evEdge), .eventPinFunction(evFunc), .irqEnableHigh(enHi),
        .irqEnableLow(enLo), .irqClearHigh(1'b0), .irqClearLow(clrLo),
        .irqRequestHigh(reqHi), .irqRequestLow(reqLo), .cpuIrqHigh(cpuHi),
        .cpuIrqLow(cpuLo));
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
        cpu_u.rd(a, v);
        check(what, v, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic test_reset();
        check("pins", {6'h00, hiPin, loPin}, 8'h00);
        rchk("count high", ADDR_COUNT_HIGH, 8'h00);
        rchk("count low", ADDR_COUNT_LOW, 8'h00);
        rchk("compare high", ADDR_COMPARE_HIGH, 8'hFF);
        rchk("compare low", ADDR_COMPARE_LOW, 8'hFF);
        rchk("status", ADDR_STATUS, 8'h00);
        rchk("control", ADDR_CONTROL, 8'hFF);
        rchk("clock stop", ADDR_CLOCK_STOP, 8'hFF);
        rchk("unmapped", 16'hFFBC, 8'h00);
        $display("test_reset done");
    endtask
    task automatic test_wide();
        cpu_u.wr(ADDR_COUNT_HIGH, 8'hAA);
        cpu_u.wr(ADDR_COUNT_LOW, 8'h55);
        cpu_u.wr(ADDR_COUNT_HIGH, 8'h11);
        rchk("wide high", ADDR_COUNT_HIGH, 8'hAA);
        rchk("wide low", ADDR_COUNT_LOW, 8'h55);
        cpu_u.wr(ADDR_CONTROL, 8'h06);
        cpu_u.wr(ADDR_COUNT_HIGH, 8'h00);
        cpu_u.wr(ADDR_COUNT_LOW, 8'hFE);
        repeat (20) @(negedge clk);
        rchk("cascade carry", ADDR_COUNT_HIGH, 8'h01);
        $display("test_wide done");
    endtask
    task automatic test_split();
        enLo = 1'b1;
        // split first, so the compare write bypasses the shared latch
        cpu_u.wr(ADDR_CONTROL, 8'h66);
        cpu_u.wr(ADDR_COMPARE_LOW, 8'h02);
        cpu_u.wr(ADDR_STATUS, 8'h21);
        cpu_u.wr(ADDR_COUNT_LOW, 8'h00);
        cpu_u.wr(ADDR_COUNT_HIGH, 8'h00);
        for (int i = 0; i < 100 && reqLo !== 1'b1; i++) @(negedge clk);
        check("low pin", {7'h00, loPin}, 8'h01);
        check("low irq", {7'h00, cpuLo}, 8'h01);
        repeat (1200) @(negedge clk);
        // low half clears at 2, so its overflow flag must stay clear
        rchk("split flags", ADDR_STATUS, 8'hE5);
        check("high irq", {7'h00, cpuHi}, 8'h01);
        check("high request", {7'h00, reqHi}, 8'h01);
        $display("test_split done");
    endtask
    task automatic test_stop();
        cpu_u.wr(ADDR_CLOCK_STOP, 8'hFB);
        cpu_u.rd(ADDR_COUNT_HIGH, v);
        repeat (40) @(negedge clk);
        rchk("halted", ADDR_COUNT_HIGH, v);
        rchk("armed read", ADDR_STATUS, 8'hE5);
        cpu_u.wr(ADDR_STATUS, 8'h21);
        rchk("flags cleared", ADDR_STATUS, 8'h21);
        cpu_u.wr(ADDR_STATUS, 8'hCC);
        rchk("flags not set", ADDR_STATUS, 8'h00);
        cpu_u.wr(ADDR_CONTROL, 8'h66);
        check("levels low", {6'h00, hiPin, loPin}, 8'h00);
        cpu_u.wr(ADDR_CONTROL, 8'hEE);
        check("levels high", {6'h00, hiPin, loPin}, 8'h03);
        clrLo = 1'b1;
        @(negedge clk);
        clrLo = 1'b0;
        check("request cleared", {7'h00, reqLo}, 8'h00);
        $display("test_stop done");
    endtask
    task automatic test_event();
        // set up while halted, so no stray tick reaches the compare value
        cpu_u.wr(ADDR_CONTROL, 8'h40);
        cpu_u.wr(ADDR_COUNT_LOW, 8'hFE);
        cpu_u.wr(ADDR_CLOCK_STOP, 8'hFF);
        evFunc = 1'b1;
        repeat (6) @(negedge clk);
        rchk("function switch", ADDR_COUNT_LOW, 8'hFF);
        evPin = 1'b1;
        repeat (6) @(negedge clk);
        evPin = 1'b0;
        repeat (6) @(negedge clk);
        rchk("falling edge", ADDR_COUNT_LOW, 8'h00);
        check("low request", {7'h00, reqLo}, 8'h00);
        cpu_u.rd(ADDR_STATUS, v);
        check("low overflow", v & 8'h08, 8'h08);
        evEdge = 1'b1;
        evPin  = 1'b1;
        repeat (6) @(negedge clk);
        rchk("rising edge", ADDR_COUNT_LOW, 8'h01);
        $display("test_event done");
    endtask
    task automatic test_wide_clear();
        cpu_u.wr(ADDR_CONTROL, 8'h06);
        cpu_u.wr(ADDR_STATUS, 8'h10);
        cpu_u.wr(ADDR_COMPARE_HIGH, 8'h00);
        cpu_u.wr(ADDR_COMPARE_LOW, 8'h03);
        cpu_u.wr(ADDR_COUNT_HIGH, 8'h00);
        cpu_u.wr(ADDR_COUNT_LOW, 8'h00);
        repeat (40) @(negedge clk);
        rchk("wide clear high", ADDR_COUNT_HIGH, 8'h00);
        cpu_u.rd(ADDR_COUNT_LOW, v);
        check("wide clear low", v & 8'hFC, 8'h00);
        cpu_u.rd(ADDR_STATUS, v);
        check("wide match flag", v & 8'h40, 8'h40);
        $display("test_wide_clear done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        test_reset();
        test_wide();
        test_split();
        test_stop();
        test_event();
        test_wide_clear();
        print_verdict();
    end
endmodule
